// ===== dioa_params.svh
// Purpose: Named constants for the digital input override alarm block
// Assumes: 250 MHz reference clock
// Notes:   Included by every design file and the bench, not by the package
`ifndef DIOA_PARAMS_SVH
`define DIOA_PARAMS_SVH

// Register byte offsets
`define DIOA_OFS_CTRL      8'h00
`define DIOA_OFS_STATUS    8'h04
`define DIOA_OFS_COUNT     8'h08
`define DIOA_OFS_DEST      8'h0C
`define DIOA_OFS_FAILS     8'h10
`define DIOA_OFS_ALARM     8'h14
`define DIOA_OFS_TEXT_LO   8'h20
`define DIOA_OFS_TEXT_HI   8'h3C

// Control register fields
`define DIOA_CTRL_INV      0
`define DIOA_CTRL_OVR      1
`define DIOA_CTRL_FORCED   2
`define DIOA_CTRL_INTMODE  3
`define DIOA_CTRL_INTVAL   4
`define DIOA_CTRL_W        5

// Alarm configuration fields
`define DIOA_PRIO_LSB      0
`define DIOA_DELAY_LSB     8

// Widths, limits, reset values
`define DIOA_CNT_W         24
`define DIOA_CNT_MAX       24'd10_000_000
`define DIOA_FAIL_MAX      4'd9
`define DIOA_DEST_W        16
`define DIOA_TEXT_W        120
`define DIOA_SECS_W        13
`define DIOA_RST_ZERO      32'h0000_0000

// Delay code decode, in seconds
`define DIOA_DLY_SEC_MAX   8'd250
`define DIOA_DLY_C251      8'd251
`define DIOA_DLY_C252      8'd252
`define DIOA_DLY_C253      8'd253
`define DIOA_DLY_C254      8'd254
`define DIOA_DLY_S251      13'd900
`define DIOA_DLY_S252      13'd1800
`define DIOA_DLY_S253      13'd2700
`define DIOA_DLY_S254      13'd3600
`define DIOA_DLY_S255      13'd4500

// Timing
`define DIOA_SEC_NS        1_000_000_000
`define DIOA_CLK_NS        4
`define DIOA_TEXT_WORDS    3'd4

`endif

// ===== dioa_pkg.sv
// Purpose: Types for the digital input override alarm block
// Assumes: dioa_params.svh holds every number
// Notes:   Alarm sequencer states only
package dioa_pkg;

  typedef enum logic [1:0] {
    DIOA_AL_IDLE,
    DIOA_AL_FETCH,
    DIOA_AL_SEND
  } dioa_alarm_state_type;

endpackage : dioa_pkg

// ===== dioa_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for a pin
// Assumes: Input is asynchronous to i_ref_clk
// Notes:   Level follows once the second and third stages agree
`include "dioa_params.svh"
module dioa_sync
  import dioa_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  // Pin and filtered level
  input  wire logic i_async,
  output logic      o_level
);

  logic [2:0] stage_r;
  logic       level_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      stage_r <= 3'h0;
    else
      stage_r <= {stage_r[1:0], i_async};
  end

  // Stage 0 is read only by stage 1
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      level_r <= 1'b0;
    else if (stage_r[1] == stage_r[2])
      level_r <= stage_r[2];
  end

  assign o_level = level_r;

endmodule : dioa_sync

// ===== dioa_text_mem.sv
// Purpose: Condition text store, off text in words 0-3, on text in 4-7
// Assumes: One write port, two read ports
// Notes:   Read data are registered, one cycle after the address
`include "dioa_params.svh"
module dioa_text_mem
  import dioa_pkg::*;
(
  // Clock
  input  wire logic        i_ref_clk,
  // Write port
  input  wire logic        i_wr_en,
  input  wire logic [2:0]  i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  // Read port A
  input  wire logic [2:0]  i_rda_addr,
  output logic      [31:0] o_rda_data,
  // Read port B
  input  wire logic [2:0]  i_rdb_addr,
  output logic      [31:0] o_rdb_data
);

  logic [31:0] mem_r [0:7];
  logic [31:0] rda_r;
  logic [31:0] rdb_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_wr_en)
      mem_r[i_wr_addr] <= i_wr_data;
  end

  always_ff @(posedge i_ref_clk)
  begin
    rda_r <= mem_r[i_rda_addr];
    rdb_r <= mem_r[i_rdb_addr];
  end

  assign o_rda_data = rda_r;
  assign o_rdb_data = rdb_r;

endmodule : dioa_text_mem

// ===== dioa_top.sv
// Purpose: Digital input conditioning, forwarding and off/on alarms
// Assumes: APB3 slave, one wait state on every access
// Notes:   Condition texts live in a small memory behind the bus
//
// Decided for this implementation: the address map and the APB slave port.
`include "dioa_params.svh"
module dioa_top
  import dioa_pkg::*;
#(
  parameter int CYC_PER_SEC = `DIOA_SEC_NS / `DIOA_CLK_NS
)
(
  // Clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_sys_rst,
  // APB slave
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [7:0]               i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // Field input
  input  wire logic                     i_raw_input_level,
  // Calculated state
  output logic                          o_state,
  // Destination forwarding
  output logic                          o_fwd_req,
  output logic                          o_fwd_value,
  output logic      [`DIOA_DEST_W-1:0]  o_fwd_dest,
  input  wire logic                     i_fwd_ack,
  input  wire logic                     i_fwd_ok,
  // Alarm output
  output logic                          o_alarm_req,
  output logic                          o_alarm_state,
  output logic      [3:0]               o_alarm_prio,
  output logic      [`DIOA_TEXT_W-1:0]  o_alarm_text,
  input  wire logic                     i_alarm_ack
);

  localparam logic [27:0] SEC_LAST = 28'(CYC_PER_SEC - 1);

  logic                       raw_level;
  logic                       raw_prev_r;
  logic [`DIOA_CTRL_W-1:0]    ctrl_r;
  logic [`DIOA_CNT_W-1:0]     count_r;
  logic [`DIOA_DEST_W-1:0]    dest_r;
  logic [3:0]                 fails_r;
  logic [3:0]                 prio_r;
  logic [7:0]                 delay_code_r;
  logic                       calc_r;
  logic                       calc_nxt;
  logic                       changed;
  logic                       pready_r;
  logic                       pslverr_r;
  logic [31:0]                prdata_r;
  logic [31:0]                rd_mux;
  logic                       mapped;
  logic                       text_sel;
  logic                       wr_en;
  logic [31:0]                mem_rda;
  logic [31:0]                mem_rdb;
  logic                       fwd_req_r;
  logic                       fwd_val_r;
  logic                       fwd_pend_r;
  logic [27:0]                presc_r;
  logic [`DIOA_SECS_W-1:0]    secs_r;
  logic [`DIOA_SECS_W-1:0]    delay_secs;
  logic                       alarmed_r;
  logic                       alarm_due;
  dioa_alarm_state_type       al_state_r;
  logic [2:0]                 fetch_r;
  logic                       al_val_r;
  logic [3:0]                 al_prio_r;
  logic                       al_req_r;
  logic [127:0]               text_r;

  dioa_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_raw_input_level),
    .o_level   (raw_level)
  );

  // APB decode; completion is the second access cycle
  assign text_sel = (i_paddr >= `DIOA_OFS_TEXT_LO) && (i_paddr <= `DIOA_OFS_TEXT_HI);
  assign wr_en    = i_psel && i_penable && pready_r && i_pwrite && !pslverr_r;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = `DIOA_RST_ZERO;
    if (i_paddr[1:0] != 2'b00)
      mapped = 1'b0;
    else if (text_sel)
      rd_mux = mem_rda;
    else
    begin
      case (i_paddr)
        `DIOA_OFS_CTRL:   rd_mux[`DIOA_CTRL_W-1:0] = ctrl_r;
        `DIOA_OFS_STATUS: rd_mux[2:0] = {alarmed_r, calc_r, raw_level};
        `DIOA_OFS_COUNT:  rd_mux[`DIOA_CNT_W-1:0] = count_r;
        `DIOA_OFS_DEST:   rd_mux[`DIOA_DEST_W-1:0] = dest_r;
        `DIOA_OFS_FAILS:  rd_mux[3:0] = fails_r;
        `DIOA_OFS_ALARM:
        begin
          rd_mux[`DIOA_PRIO_LSB +: 4]  = prio_r;
          rd_mux[`DIOA_DELAY_LSB +: 8] = delay_code_r;
        end
        default:          mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `DIOA_RST_ZERO;
    end
    else if (i_psel && i_penable && !pready_r)
    begin
      pready_r  <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r  <= (mapped && !i_pwrite) ? rd_mux : `DIOA_RST_ZERO;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  dioa_text_mem u_text (
    .i_ref_clk  (i_ref_clk),
    .i_wr_en    (wr_en && text_sel),
    .i_wr_addr  (i_paddr[4:2]),
    .i_wr_data  (i_pwdata),
    .i_rda_addr (i_paddr[4:2]),
    .o_rda_data (mem_rda),
    .i_rdb_addr ({al_val_r, fetch_r[1:0]}),
    .o_rdb_data (mem_rdb)
  );

  // Configuration registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_r       <= `DIOA_CTRL_W'(`DIOA_RST_ZERO);
      dest_r       <= `DIOA_DEST_W'(`DIOA_RST_ZERO);
      prio_r       <= 4'(`DIOA_RST_ZERO);
      delay_code_r <= 8'(`DIOA_RST_ZERO);
    end
    else if (wr_en)
    begin
      case (i_paddr)
        `DIOA_OFS_CTRL: ctrl_r <= i_pwdata[`DIOA_CTRL_W-1:0];
        `DIOA_OFS_DEST: dest_r <= i_pwdata[`DIOA_DEST_W-1:0];
        `DIOA_OFS_ALARM:
        begin
          // Priorities above nine are held at nine
          prio_r <= (i_pwdata[`DIOA_PRIO_LSB +: 4] > `DIOA_FAIL_MAX) ?
                    `DIOA_FAIL_MAX : i_pwdata[`DIOA_PRIO_LSB +: 4];
          delay_code_r <= i_pwdata[`DIOA_DELAY_LSB +: 8];
        end
        default: ;
      endcase
    end
  end

  // Calculated state
  always_comb
  begin
    if (ctrl_r[`DIOA_CTRL_INTMODE])
      calc_nxt = ctrl_r[`DIOA_CTRL_INTVAL];
    else if (ctrl_r[`DIOA_CTRL_OVR])
      calc_nxt = ctrl_r[`DIOA_CTRL_FORCED];
    else
      calc_nxt = raw_level ^ ctrl_r[`DIOA_CTRL_INV];
  end

  assign changed = (calc_nxt != calc_r);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      calc_r <= 1'b0;
    else
      calc_r <= calc_nxt;
  end

  // Rising-edge counter of the raw level; an edge in a write cycle adds to a written value below DIOA_CNT_MAX
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      raw_prev_r <= 1'b0;
      count_r    <= `DIOA_CNT_W'(`DIOA_RST_ZERO);
    end
    else
    begin
      raw_prev_r <= raw_level;
      if (wr_en && i_paddr == `DIOA_OFS_COUNT)
      begin
        if (i_pwdata[`DIOA_CNT_W-1:0] >= `DIOA_CNT_MAX)
          count_r <= `DIOA_CNT_MAX;
        else
          count_r <= i_pwdata[`DIOA_CNT_W-1:0] + `DIOA_CNT_W'(raw_level && !raw_prev_r);
      end
      else if (raw_level && !raw_prev_r && count_r < `DIOA_CNT_MAX)
        count_r <= count_r + `DIOA_CNT_W'(1);
    end
  end

  // Forwarding: changes during a pending request are merged, latest value wins
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      fwd_req_r  <= 1'b0;
      fwd_val_r  <= 1'b0;
      fwd_pend_r <= 1'b0;
    end
    else if (fwd_req_r && i_fwd_ack)
    begin
      fwd_val_r  <= calc_nxt;
      fwd_req_r  <= fwd_pend_r || changed;
      fwd_pend_r <= 1'b0;
    end
    else if (changed)
    begin
      if (fwd_req_r)
        fwd_pend_r <= 1'b1;
      else
      begin
        fwd_req_r <= 1'b1;
        fwd_val_r <= calc_nxt;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      fails_r <= 4'(`DIOA_RST_ZERO);
    else if (fwd_req_r && i_fwd_ack)
    begin
      if (i_fwd_ok)
        fails_r <= 4'(`DIOA_RST_ZERO);
      else if (fails_r < `DIOA_FAIL_MAX)
        fails_r <= fails_r + 4'd1;
    end
  end

  // Hold timer restarts on every change so whole seconds are exact
  always_comb
  begin
    case (delay_code_r)
      `DIOA_DLY_C251: delay_secs = `DIOA_DLY_S251;
      `DIOA_DLY_C252: delay_secs = `DIOA_DLY_S252;
      `DIOA_DLY_C253: delay_secs = `DIOA_DLY_S253;
      `DIOA_DLY_C254: delay_secs = `DIOA_DLY_S254;
      default:
        delay_secs = (delay_code_r > `DIOA_DLY_SEC_MAX) ? `DIOA_DLY_S255 :
                     `DIOA_SECS_W'(delay_code_r);
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || changed)
    begin
      presc_r <= 28'(`DIOA_RST_ZERO);
      secs_r  <= `DIOA_SECS_W'(`DIOA_RST_ZERO);
    end
    else if (presc_r == SEC_LAST)
    begin
      presc_r <= 28'(`DIOA_RST_ZERO);
      if (secs_r < `DIOA_DLY_S255)
        secs_r <= secs_r + `DIOA_SECS_W'(1);
    end
    else
      presc_r <= presc_r + 28'd1;
  end

  assign alarm_due = (prio_r != 4'(`DIOA_RST_ZERO)) && !alarmed_r &&
                     (secs_r >= delay_secs) && !changed &&
                     (al_state_r == DIOA_AL_IDLE);

  // One alarm per steady period; a change re-arms it
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || changed)
      alarmed_r <= 1'b0;
    else if (alarm_due)
      alarmed_r <= 1'b1;
  end

  // Alarm sequencer: fetch four text words, then hold the request
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      al_state_r <= DIOA_AL_IDLE;
      fetch_r    <= 3'h0;
      al_val_r   <= 1'b0;
      al_prio_r  <= 4'h0;
      al_req_r   <= 1'b0;
      text_r     <= 128'h0;
    end
    else
    begin
      case (al_state_r)
        DIOA_AL_IDLE:
        begin
          if (alarm_due)
          begin
            al_val_r   <= calc_r;
            al_prio_r  <= prio_r;
            fetch_r    <= 3'h0;
            al_state_r <= DIOA_AL_FETCH;
          end
        end
        DIOA_AL_FETCH:
        begin
          if (fetch_r != 3'h0)
            // Word k arrives one step after its address, so the fourth lands at count four
            text_r[32*(2'(fetch_r - 3'd1)) +: 32] <= mem_rdb;
          if (fetch_r == `DIOA_TEXT_WORDS)
          begin
            al_req_r   <= 1'b1;
            al_state_r <= DIOA_AL_SEND;
          end
          else
            fetch_r <= fetch_r + 3'd1;
        end
        DIOA_AL_SEND:
        begin
          if (i_alarm_ack)
          begin
            al_req_r   <= 1'b0;
            al_state_r <= DIOA_AL_IDLE;
          end
        end
        default: al_state_r <= DIOA_AL_IDLE;
      endcase
    end
  end

  assign o_prdata      = prdata_r;
  assign o_pready      = pready_r;
  assign o_pslverr     = pslverr_r;
  assign o_state       = calc_r;
  assign o_fwd_req     = fwd_req_r;
  assign o_fwd_value   = fwd_val_r;
  assign o_fwd_dest    = dest_r;
  assign o_alarm_req   = al_req_r;
  assign o_alarm_state = al_val_r;
  assign o_alarm_prio  = al_prio_r;
  assign o_alarm_text  = text_r[`DIOA_TEXT_W-1:0];

endmodule : dioa_top

// ===== dioa_checker.sv
// Purpose: Port assertions for dioa_top
// Assumes: One clock, synchronous reset
// Notes:   Bound into every dioa_top
`include "dioa_params.svh"
module dioa_checker
  import dioa_pkg::*;
(
  // Watched ports
  input wire logic                    i_ref_clk,
  input wire logic                    i_sys_rst,
  input wire logic                    i_psel,
  input wire logic                    i_penable,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire logic                    o_state,
  input wire logic                    o_fwd_req,
  input wire logic                    o_fwd_value,
  input wire logic                    i_fwd_ack,
  input wire logic                    o_alarm_req,
  input wire logic                    o_alarm_state,
  input wire logic [3:0]              o_alarm_prio,
  input wire logic [`DIOA_TEXT_W-1:0] o_alarm_text,
  input wire logic                    i_alarm_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_wait;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_steady;
    $stable(o_state) [*8];
  endsequence
  a_one_wait: assert property (s_setup ##1 s_wait |=> o_pready)
    else $error("pready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_fwd_change: assert property (o_state != $past(o_state) |-> o_fwd_req)
    else $error("state change not forwarded");
  a_fwd_value: assert property ($rose(o_fwd_req) |-> o_fwd_value == o_state)
    else $error("forward value differs from state");
  a_fwd_hold: assert property (o_fwd_req && !i_fwd_ack |=> o_fwd_req && $stable(o_fwd_value))
    else $error("forward dropped before ack");
  a_alarm_hold: assert property (o_alarm_req && !i_alarm_ack |=>
    o_alarm_req && $stable(o_alarm_text) && $stable(o_alarm_prio))
    else $error("alarm changed before ack");
  a_prio_range: assert property (o_alarm_req |-> o_alarm_prio inside {[1:9]})
    else $error("alarm priority out of range");
  a_alarm_state: assert property (s_steady ##1 $rose(o_alarm_req) |->
    o_alarm_state == o_state)
    else $error("alarm state differs from steady state");
endmodule : dioa_checker

bind dioa_top dioa_checker i_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_state(o_state), .o_fwd_req(o_fwd_req), .o_fwd_value(o_fwd_value),
  .i_fwd_ack(i_fwd_ack), .o_alarm_req(o_alarm_req), .o_alarm_state(o_alarm_state),
  .o_alarm_prio(o_alarm_prio), .o_alarm_text(o_alarm_text), .i_alarm_ack(i_alarm_ack)
);

// ===== dioa_partner.sv
// Purpose: Field contact and forward destination model
// Assumes: Bench commands contact level and answer kind
// Notes:   Ack arrives i_lat + 1 cycles after a request
module dioa_partner (
  // Clock
  input  wire logic       i_ref_clk,
  // Bench commands
  input  wire logic       i_level,
  input  wire logic       i_ok_mode,
  input  wire logic [3:0] i_lat,
  // Forward interface
  input  wire logic       i_fwd_req,
  output logic            o_pin,
  output logic            o_fwd_ack,
  output logic            o_fwd_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r = 4'h0;
  initial
  begin
    o_pin = 1'b0;
    o_fwd_ack = 1'b0;
    o_fwd_ok = 1'b0;
  end
  always @(posedge i_ref_clk)
  begin
    o_pin <= i_level;
    o_fwd_ack <= 1'b0;
    // Toggles outside an ack so a stray sample is not a steady value
    o_fwd_ok <= ~o_fwd_ok;
    if (i_fwd_req && !o_fwd_ack)
    begin
      if (cnt_r == i_lat)
      begin
        o_fwd_ack <= 1'b1;
        o_fwd_ok <= i_ok_mode;
        cnt_r <= 4'h0;
      end
      else
        cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : dioa_partner

// ===== tb_top.sv
// Purpose: Self-checking bench for dioa_top
// Assumes: Seconds shortened to CPS cycles
// Notes:   Model state kept in bench variables
`include "dioa_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPS = 2;
  logic         ref_clk = 0, sys_rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0000_0000, prdata, rd, r;
  logic         pready, pslverr, err, lvl = 0, ok_mode = 0, pin, fack, fok;
  logic         st, freq, fval, areq, ast, aack = 0, old;
  logic [3:0]   lat = 4'h0, aprio, p;
  logic [15:0]  fdest, m_dest = 16'h0000;
  logic [119:0] atext;
  logic [4:0]   ctrl = 5'h00;
  logic [31:0]  w [8];
  logic [7:0]   codes [7] = '{8'h00, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
  logic [4:0]   tbl [6] = '{5'h01, 5'h03, 5'h07, 5'h05, 5'h18, 5'h0f};
  logic [31:0]  seed = 32'h81a6_f00c;
  int           n_fail = 0, checks = 0, m_cnt = 0, m_fails = 0, n_al = 0, c, s;
  always #2 ref_clk = ~ref_clk;
  dioa_top #(.CYC_PER_SEC(CPS)) i_dut (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_raw_input_level(pin), .o_state(st),
    .o_fwd_req(freq), .o_fwd_value(fval), .o_fwd_dest(fdest), .i_fwd_ack(fack),
    .i_fwd_ok(fok), .o_alarm_req(areq), .o_alarm_state(ast), .o_alarm_prio(aprio),
    .o_alarm_text(atext), .i_alarm_ack(aack));
  dioa_partner i_part (.i_ref_clk(ref_clk), .i_level(lvl), .i_ok_mode(ok_mode),
    .i_lat(lat), .i_fwd_req(freq), .o_pin(pin), .o_fwd_ack(fack), .o_fwd_ok(fok));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic exp_st(input logic v);
    return ctrl[3] ? ctrl[4] : (ctrl[1] ? ctrl[2] : v ^ ctrl[0]);
  endfunction : exp_st
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      n_fail++;
      complete_run();
    end
  endtask : tmo
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    pen <= 1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    tmo(n, 20);
  endtask : apb
  task automatic setlvl(input logic v);
    if (v && !lvl)
      m_cnt++;
    @(posedge ref_clk);
    lvl <= v;
    // Room for the slowest forward ack before the model's mode may change
    repeat (12) @(posedge ref_clk);
    chk("state", {31'h0, st}, {31'h0, exp_st(v)});
  endtask : setlvl
  always @(posedge ref_clk)
  begin
    aack <= areq && !aack;
    if (areq === 1'b1 && aack === 1'b0)
      n_al++;
    if (freq === 1'b1 && fack === 1'b1)
    begin
      m_fails = fok ? 0 : (m_fails < 9 ? m_fails + 1 : 9);
      chk("fwd_value", {31'h0, fval}, {31'h0, exp_st(lvl)});
      chk("fwd_dest", {16'h0, fdest}, {16'h0, m_dest});
    end
  end
  initial
  begin
    for (int i = 0; i < 8; i++)
      w[i] = rnd();
    r = rnd();
    lat <= {2'b00, r[1:0]};
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
    @(posedge ref_clk);
    chk("rst_out", {29'h0, st, freq, areq}, 32'h0000_0000);
    apb(0, `DIOA_OFS_CTRL, 32'h0000_0000);
    chk("ctrl_rst", rd, 32'h0000_0000);
    apb(0, 8'h18, 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    m_dest = r[31:16];
    apb(1, `DIOA_OFS_DEST, {16'h0, m_dest});
    for (int i = 0; i < 8; i++)
      apb(1, 8'h20 + 8'(4 * i), w[i]);
    apb(0, `DIOA_OFS_TEXT_LO, 32'h0000_0000);
    chk("text_rd", rd, w[0]);
    // Failing destination, enough changes to reach the cap
    c = 5 + int'(r[3:2]);
    for (int i = 0; i < c; i++)
    begin
      setlvl(1);
      setlvl(0);
    end
    apb(0, `DIOA_OFS_FAILS, 32'h0000_0000);
    chk("fails_sat", rd, 32'h0000_0009);
    ok_mode <= 1;
    setlvl(1);
    apb(0, `DIOA_OFS_FAILS, 32'h0000_0000);
    chk("fails_clr", rd, 32'(m_fails));
    apb(0, `DIOA_OFS_COUNT, 32'h0000_0000);
    chk("count", rd, 32'(m_cnt));
    apb(0, `DIOA_OFS_STATUS, 32'h0000_0000);
    chk("status", rd, {29'h0, 1'b0, exp_st(lvl), lvl});
    for (int i = 0; i < 6; i++)
    begin
      r = rnd();
      setlvl(r[0]);
      ctrl = tbl[i];
      apb(1, `DIOA_OFS_CTRL, {27'h0, ctrl});
      repeat (10) @(posedge ref_clk);
      chk("state_mode", {31'h0, st}, {31'h0, exp_st(lvl)});
    end
    apb(1, `DIOA_OFS_COUNT, 32'h0098_9685);
    apb(0, `DIOA_OFS_COUNT, 32'h0000_0000);
    chk("count_sat", rd, 32'h0098_9680);
    // Priority 0 so far: no alarm may have been seen
    ctrl = 5'h02;
    apb(1, `DIOA_OFS_CTRL, {27'h0, ctrl});
    chk("alarm_none", 32'(n_al), 32'h0000_0000);
    apb(1, `DIOA_OFS_ALARM, 32'h0000_0001);
    repeat (40) @(posedge ref_clk);
    chk("alarm_first", 32'(n_al), 32'h0000_0001);
    for (int i = 0; i < 7; i++)
    begin
      p = (i == 0) ? 4'hc : 4'(i);
      apb(1, `DIOA_OFS_ALARM, {16'h0, codes[i], 4'h0, p});
      if (p > 4'h9)
        p = 4'h9;
      apb(0, `DIOA_OFS_ALARM, 32'h0000_0000);
      chk("alarm_cfg", rd, {16'h0, codes[i], 4'h0, p});
      ctrl[2] = ~ctrl[2];
      old = st;
      apb(1, `DIOA_OFS_CTRL, {27'h0, ctrl});
      for (c = 0; c < 20 && st === old; c++)
        @(posedge ref_clk);
      tmo(c, 20);
      s = (codes[i] <= 8'hfa) ? int'(codes[i]) : (int'(codes[i]) - 250) * 900;
      s = s * CPS;
      for (c = 0; c < s + 20; c++)
      begin
        @(posedge ref_clk);
        if (areq === 1'b1)
          break;
      end
      tmo(c, s + 20);
      chk("alarm_delay", (c >= s && c <= s + 10) ? 32'h1 : 32'h0, 32'h1);
      chk("alarm_state", {31'h0, ast}, {31'h0, ctrl[2]});
      chk("alarm_prio", {28'h0, aprio}, {28'h0, p});
      chk("alarm_text", {31'h0, atext === (ctrl[2] ? {w[7][23:0], w[6], w[5], w[4]}
        : {w[3][23:0], w[2], w[1], w[0]})}, 32'h1);
      repeat (4) @(posedge ref_clk);
      chk("alarm_once", 32'(n_al), 32'(i + 2));
    end
    complete_run();
  end
endmodule : tb_top
